// File: oefl_pkg.sv
// Constants, register map and carrier types for the OTG event flag latches.
// Assumes a 10 MHz aclk and an AXI4-Lite master with 32-bit data.
package oefl_pkg;

  localparam int OEFL_ADDR_W = 4;
  localparam int OEFL_DATA_W = 32;
  localparam int OEFL_REG_W = 16;

  // Register byte offsets
  localparam logic [OEFL_ADDR_W-1:0] OEFL_OFS_FLAGS = 4'h0;
  localparam logic [OEFL_ADDR_W-1:0] OEFL_OFS_ENABLES = 4'h4;
  localparam logic [OEFL_ADDR_W-1:0] OEFL_OFS_CONTROL = 4'h8;
  localparam logic [OEFL_ADDR_W-1:0] OEFL_OFS_STATE = 4'hC;

  // Flag and status bit positions
  localparam int OEFL_BIT_TIMER = 10;
  localparam int OEFL_BIT_LONG_SE0 = 9;
  localparam int OEFL_BIT_SRP = 8;
  localparam int OEFL_BIT_RESUME = 7;
  localparam int OEFL_BIT_SUSPEND = 6;
  localparam int OEFL_BIT_RMT = 5;
  localparam int OEFL_BIT_BSV = 4;
  localparam int OEFL_BIT_ASV = 3;
  localparam int OEFL_FLAG_LO = 3;
  localparam int OEFL_FLAG_HI = 10;
  localparam int OEFL_NFLAGS = OEFL_FLAG_HI - OEFL_FLAG_LO + 1;
  localparam int OEFL_SEL_BIT = 9;
  localparam int OEFL_SUSP_STATE_BIT = 6;

  // Implemented bits of each register; the rest read zero
  localparam logic [OEFL_REG_W-1:0] OEFL_FLAG_MASK = 16'h07F8;
  localparam logic [OEFL_REG_W-1:0] OEFL_ENABLE_MASK = 16'h07F8;
  localparam logic [OEFL_REG_W-1:0] OEFL_CONTROL_MASK = 16'h0200;
  localparam logic [OEFL_REG_W-1:0] OEFL_REG_RESET = 16'h0000;

  localparam logic [1:0] OEFL_RESP_OKAY = 2'h0;
  localparam logic [1:0] OEFL_RESP_SLVERR = 2'h2;

  // Timing
  localparam int OEFL_CLK_KHZ = 10000;
  localparam int OEFL_LONG_SE0_US = 2000;
  localparam int OEFL_SUSPEND_IDLE_US = 3000;
  localparam int OEFL_LONG_SE0_CYCLES = OEFL_LONG_SE0_US * OEFL_CLK_KHZ / 1000;
  localparam int OEFL_SUSPEND_IDLE_CYCLES =
    OEFL_SUSPEND_IDLE_US * OEFL_CLK_KHZ / 1000;
  localparam int OEFL_CNT_W = 16;

  // Bus line state, sampled levels
  typedef struct packed {
    logic se0;
    logic j;
    logic k;
  } oefl_line_t;

  // Analog comparator and detector levels and pulses
  typedef struct packed {
    logic remote_pullup_present;
    logic b_session_valid;
    logic a_session_valid;
    logic vbus_pulse_seen;
    logic data_line_pulse_seen;
    logic timer_timeout;
  } oefl_status_in_t;

  typedef struct packed {
    logic q;
  } oefl_cell_state_t;

endpackage

// File: oefl_flag_cell.sv
// One sticky event flag with write-one-to-clear.
// Assumes set and clear are single-cycle strobes in the aclk domain.
`timescale 1ns/10ps
module oefl_flag_cell (
  // Clock and reset
  input wire logic aclk,
  input wire logic aresetn,
  // Event and software clear
  input wire logic set,
  input wire logic clear,
  // Flag
  output logic q
);
  import oefl_pkg::*;

  oefl_cell_state_t state;
  oefl_cell_state_t next_state;

  always_comb begin
    next_state = state;
    if (set) begin
      next_state.q = 1'b1;
    end else if (clear) begin
      next_state.q = 1'b0;
    end
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      state <= '0;
    end else begin
      state <= next_state;
    end
  end

  assign q = state.q;
endmodule

// File: oefl_top.sv
// OTG event flag latches, bits 10 to 3, with an AXI4-Lite register slave.
// Assumes all inputs are synchronous to aclk; timer_timeout, vbus and
// data-line pulse inputs are one-cycle strobes, the rest are levels.
`timescale 1ns/10ps
module oefl_top #(
  parameter int LONG_SE0_CYCLES = oefl_pkg::OEFL_LONG_SE0_CYCLES,
  parameter int SUSPEND_IDLE_CYCLES = oefl_pkg::OEFL_SUSPEND_IDLE_CYCLES
) (
  // Clock and reset
  input wire logic aclk,
  input wire logic aresetn,
  // AXI4-Lite write address
  input wire logic awvalid,
  output logic awready,
  input wire logic [oefl_pkg::OEFL_ADDR_W-1:0] awaddr,
  input wire logic [2:0] awprot,
  // AXI4-Lite write data
  input wire logic wvalid,
  output logic wready,
  input wire logic [oefl_pkg::OEFL_DATA_W-1:0] wdata,
  input wire logic [3:0] wstrb,
  // AXI4-Lite write response
  output logic bvalid,
  input wire logic bready,
  output logic [1:0] bresp,
  // AXI4-Lite read address
  input wire logic arvalid,
  output logic arready,
  input wire logic [oefl_pkg::OEFL_ADDR_W-1:0] araddr,
  input wire logic [2:0] arprot,
  // AXI4-Lite read data
  output logic rvalid,
  input wire logic rready,
  output logic [oefl_pkg::OEFL_DATA_W-1:0] rdata,
  output logic [1:0] rresp,
  // Bus line state and analog status
  input wire oefl_pkg::oefl_line_t line,
  input wire oefl_pkg::oefl_status_in_t status_in,
  // Outputs
  output logic [oefl_pkg::OEFL_REG_W-1:0] otg_event_flags,
  output logic timer_expiry_irq
);
  import oefl_pkg::*;

  localparam logic [OEFL_CNT_W-1:0] SE0_LIMIT =
    OEFL_CNT_W'(LONG_SE0_CYCLES);
  localparam logic [OEFL_CNT_W-1:0] IDLE_LIMIT =
    OEFL_CNT_W'(SUSPEND_IDLE_CYCLES);

  typedef struct packed {
    logic aw_held;
    logic [OEFL_ADDR_W-1:0] aw_addr;
    logic w_held;
    logic [OEFL_DATA_W-1:0] w_data;
    logic [3:0] w_strb;
    logic bvalid;
    logic [1:0] bresp;
    logic rvalid;
    logic [OEFL_DATA_W-1:0] rdata;
    logic [1:0] rresp;
    logic [OEFL_REG_W-1:0] otg_event_enables;
    logic [OEFL_REG_W-1:0] otg_control_register;
    logic prev_rmt;
    logic prev_bsv;
    logic prev_asv;
    logic prev_j;
    logic [OEFL_CNT_W-1:0] se0_cnt;
    logic long_se0;
    logic [OEFL_CNT_W-1:0] idle_cnt;
    logic suspended;
  } oefl_state_t;

  oefl_state_t state;
  oefl_state_t next_state;

  logic [OEFL_NFLAGS-1:0] flag_set;
  logic [OEFL_NFLAGS-1:0] flag_clear;
  logic [OEFL_NFLAGS-1:0] flag_q;
  logic [OEFL_REG_W-1:0] flags_word;
  logic [OEFL_REG_W-1:0] state_word;
  logic do_write;
  logic write_flags;
  logic [OEFL_REG_W-1:0] lane_mask;
  logic [OEFL_REG_W-1:0] merged;
  logic idle;
  logic long_se0_now;
  logic suspend_now;
  logic srp_event;

  // Flag word and live state word as software sees them
  always_comb begin
    flags_word = '0;
    flags_word[OEFL_FLAG_HI:OEFL_FLAG_LO] = flag_q;
    state_word = '0;
    state_word[OEFL_BIT_LONG_SE0] = state.long_se0;
    state_word[OEFL_SUSP_STATE_BIT] = state.suspended;
    state_word[OEFL_BIT_RMT] = status_in.remote_pullup_present;
    state_word[OEFL_BIT_BSV] = status_in.b_session_valid;
    state_word[OEFL_BIT_ASV] = status_in.a_session_valid;
  end

  // Bus condition detectors
  assign idle = line.j && !line.se0;
  assign long_se0_now = line.se0 && (state.se0_cnt == SE0_LIMIT);
  assign suspend_now = idle && (state.idle_cnt == IDLE_LIMIT);
  assign srp_event = state.otg_control_register[OEFL_SEL_BIT] ?
    status_in.data_line_pulse_seen : status_in.vbus_pulse_seen;

  // Event strobes into the flag cells
  always_comb begin
    flag_set = '0;
    flag_set[OEFL_BIT_TIMER-OEFL_FLAG_LO] = status_in.timer_timeout;
    flag_set[OEFL_BIT_LONG_SE0-OEFL_FLAG_LO] =
      long_se0_now && !state.long_se0;
    flag_set[OEFL_BIT_SRP-OEFL_FLAG_LO] = srp_event;
    flag_set[OEFL_BIT_RESUME-OEFL_FLAG_LO] =
      state.suspended && state.prev_j && line.k;
    flag_set[OEFL_BIT_SUSPEND-OEFL_FLAG_LO] =
      suspend_now && !state.suspended;
    flag_set[OEFL_BIT_RMT-OEFL_FLAG_LO] =
      status_in.remote_pullup_present ^ state.prev_rmt;
    flag_set[OEFL_BIT_BSV-OEFL_FLAG_LO] =
      status_in.b_session_valid ^ state.prev_bsv;
    flag_set[OEFL_BIT_ASV-OEFL_FLAG_LO] =
      status_in.a_session_valid ^ state.prev_asv;
  end

  // Write decode with byte lanes
  assign do_write = state.aw_held && state.w_held && !state.bvalid;
  assign lane_mask = {{8{state.w_strb[1]}}, {8{state.w_strb[0]}}};
  assign write_flags = do_write && (state.aw_addr == OEFL_OFS_FLAGS);
  assign flag_clear = write_flags ?
    (state.w_data[OEFL_FLAG_HI:OEFL_FLAG_LO] &
     lane_mask[OEFL_FLAG_HI:OEFL_FLAG_LO]) : '0;

  always_comb begin
    merged = '0;
    next_state = state;
    // Address and data may arrive in either order
    if (awvalid && !state.aw_held) begin
      next_state.aw_held = 1'b1;
      next_state.aw_addr = awaddr;
    end
    if (wvalid && !state.w_held) begin
      next_state.w_held = 1'b1;
      next_state.w_data = wdata;
      next_state.w_strb = wstrb;
    end
    if (do_write) begin
      next_state.aw_held = 1'b0;
      next_state.w_held = 1'b0;
      next_state.bvalid = 1'b1;
      next_state.bresp = OEFL_RESP_OKAY;
      unique case (state.aw_addr)
        OEFL_OFS_FLAGS, OEFL_OFS_STATE: begin
        end
        OEFL_OFS_ENABLES: begin
          merged = (state.otg_event_enables & ~lane_mask) |
            (state.w_data[OEFL_REG_W-1:0] & lane_mask);
          next_state.otg_event_enables = merged & OEFL_ENABLE_MASK;
        end
        OEFL_OFS_CONTROL: begin
          merged = (state.otg_control_register & ~lane_mask) |
            (state.w_data[OEFL_REG_W-1:0] & lane_mask);
          next_state.otg_control_register = merged & OEFL_CONTROL_MASK;
        end
        default: begin
          next_state.bresp = OEFL_RESP_SLVERR;
        end
      endcase
    end
    if (state.bvalid && bready) begin
      next_state.bvalid = 1'b0;
    end
    // Read channel, one outstanding read
    if (state.rvalid && rready) begin
      next_state.rvalid = 1'b0;
    end
    if (arvalid && !state.rvalid) begin
      next_state.rvalid = 1'b1;
      next_state.rresp = OEFL_RESP_OKAY;
      next_state.rdata = '0;
      unique case (araddr)
        OEFL_OFS_FLAGS: begin
          next_state.rdata[OEFL_REG_W-1:0] = flags_word;
        end
        OEFL_OFS_ENABLES: begin
          next_state.rdata[OEFL_REG_W-1:0] = state.otg_event_enables;
        end
        OEFL_OFS_CONTROL: begin
          next_state.rdata[OEFL_REG_W-1:0] = state.otg_control_register;
        end
        OEFL_OFS_STATE: begin
          next_state.rdata[OEFL_REG_W-1:0] = state_word;
        end
        default: begin
          next_state.rresp = OEFL_RESP_SLVERR;
        end
      endcase
    end
    // Status history for change detection
    next_state.prev_rmt = status_in.remote_pullup_present;
    next_state.prev_bsv = status_in.b_session_valid;
    next_state.prev_asv = status_in.a_session_valid;
    next_state.prev_j = line.j;
    // SE0 duration, saturating
    if (!line.se0) begin
      next_state.se0_cnt = '0;
    end else if (state.se0_cnt != SE0_LIMIT) begin
      next_state.se0_cnt = state.se0_cnt + 1'b1;
    end
    next_state.long_se0 = long_se0_now;
    // Idle duration and suspend state
    if (!idle) begin
      next_state.idle_cnt = '0;
    end else if (state.idle_cnt != IDLE_LIMIT) begin
      next_state.idle_cnt = state.idle_cnt + 1'b1;
    end
    if (suspend_now) begin
      next_state.suspended = 1'b1;
    end else if (!idle) begin
      next_state.suspended = 1'b0;
    end
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      state <= '0;
    end else begin
      state <= next_state;
    end
  end

  genvar gi;
  generate
    for (gi = 0; gi < OEFL_NFLAGS; gi++) begin : g_flag
      oefl_flag_cell u_cell (
        .aclk(aclk),
        .aresetn(aresetn),
        .set(flag_set[gi]),
        .clear(flag_clear[gi]),
        .q(flag_q[gi])
      );
    end
  endgenerate

  assign awready = !state.aw_held;
  assign wready = !state.w_held;
  assign bvalid = state.bvalid;
  assign bresp = state.bresp;
  assign arready = !state.rvalid;
  assign rvalid = state.rvalid;
  assign rdata = state.rdata;
  assign rresp = state.rresp;
  assign otg_event_flags = flags_word;
  assign timer_expiry_irq = flag_q[OEFL_BIT_TIMER-OEFL_FLAG_LO] &&
    state.otg_event_enables[OEFL_BIT_TIMER];
endmodule

// File: oefl_assertions.sv
// Checker for the OTG event flag latches, bound to oefl_top.
// Sees only top ports; one aclk domain.
`timescale 1ns/10ps
module oefl_checker
  import oefl_pkg::*;
(
  // Clock and reset
  input wire logic aclk,
  input wire logic aresetn,
  // Observed ports
  input wire logic bvalid,
  input wire oefl_pkg::oefl_line_t line,
  input wire oefl_pkg::oefl_status_in_t status_in,
  input wire logic [oefl_pkg::OEFL_REG_W-1:0] otg_event_flags,
  input wire logic timer_expiry_irq
);
  default clocking cb @(posedge aclk);
  endclocking
  default disable iff (!aresetn);
  a_timer_sets: assert property (
    status_in.timer_timeout |=> otg_event_flags[10])
    else $error("timer flag not set");
  a_srp_cause: assert property (
    $rose(otg_event_flags[8]) |-> $past(status_in.vbus_pulse_seen
    || status_in.data_line_pulse_seen)) else $error("srp flag no cause");
  a_resume_cause: assert property (
    $rose(otg_event_flags[7]) |-> $past(line.k) && $past(line.j, 2))
    else $error("resume flag without j to k");
  a_rmt_change: assert property (
    $past(aresetn) && !$stable(status_in.remote_pullup_present)
    |=> otg_event_flags[5]) else $error("connect change missed");
  a_bsv_change: assert property (
    $past(aresetn) && !$stable(status_in.b_session_valid)
    |=> otg_event_flags[4]) else $error("b session change missed");
  a_asv_change: assert property (
    $past(aresetn) && !$stable(status_in.a_session_valid)
    |=> otg_event_flags[3]) else $error("a session change missed");
  a_flag_sticky: assert property (
    |($past(otg_event_flags) & ~otg_event_flags) |-> $rose(bvalid))
    else $error("flag fell without write");
  a_irq_gate: assert property (
    timer_expiry_irq |-> otg_event_flags[10])
    else $error("irq without timer flag");
  a_reserved_zero: assert property (
    otg_event_flags[15:11] == 5'h0 && otg_event_flags[2:0] == 3'h0)
    else $error("reserved flag bits set");
endmodule
bind oefl_top oefl_checker u_chk (.aclk(aclk), .aresetn(aresetn),
  .bvalid(bvalid), .line(line), .status_in(status_in),
  .otg_event_flags(otg_event_flags), .timer_expiry_irq(timer_expiry_irq));

// File: oefl_top_bench.sv
// Self-checking bench for the OTG event flag latches.
// Assumes oefl_pkg, oefl_top and the checker are compiled first.
`timescale 1ns/10ps
module oefl_top_bench;
  import oefl_pkg::*;
  localparam int L = 20;
  localparam int S = 30;
  logic aclk, aresetn, awvalid, wvalid, bready, arvalid, rready;
  logic awready, wready, bvalid, arready, rvalid, irq;
  logic [3:0] awaddr, araddr;
  logic [31:0] wdata, rdata, rd, m;
  logic [1:0] bresp, rresp, rsp;
  logic [15:0] flags, ex;
  logic [5:0] v;
  oefl_line_t ln;
  oefl_status_in_t st;
  int fails, n_compared, seed;
  oefl_top #(.LONG_SE0_CYCLES(L), .SUSPEND_IDLE_CYCLES(S)) uut (
    .aclk(aclk), .aresetn(aresetn), .awvalid(awvalid), .awready(awready),
    .awaddr(awaddr), .awprot(3'h0), .wvalid(wvalid), .wready(wready),
    .wdata(wdata), .wstrb(4'hF), .bvalid(bvalid), .bready(bready),
    .bresp(bresp), .arvalid(arvalid), .arready(arready), .araddr(araddr),
    .arprot(3'h0), .rvalid(rvalid), .rready(rready), .rdata(rdata),
    .rresp(rresp), .line(ln), .status_in(st), .otg_event_flags(flags),
    .timer_expiry_irq(irq));
  task chk(input string n, input logic [31:0] s, input logic [31:0] e);
    n_compared++;
    if (s !== e) begin
      fails++;
      $display("MISMATCH %s exp %h seen %h", n, e, s);
    end
  endtask
  task summarize();
    $display("compared %0d mismatches %0d", n_compared, fails);
    if (fails == 0 && n_compared > 0) $display("All tests passed");
    else $display("Some tests failed");
    $finish;
  endtask
  task automatic wr(input logic [3:0] a, input logic [31:0] d);
    logic pa, pw;
    pa = 1;
    pw = 1;
    @(posedge aclk);
    awaddr <= a;
    wdata <= d;
    awvalid <= 1;
    wvalid <= 1;
    bready <= 1;
    while (pa | pw) begin
      @(negedge aclk);
      pa = pa & !awready;
      pw = pw & !wready;
      @(posedge aclk);
      awvalid <= pa;
      wvalid <= pw;
    end
    do @(negedge aclk); while (!bvalid);
    rsp = bresp;
    @(posedge aclk);
    bready <= 0;
  endtask
  task automatic rdr(input logic [3:0] a);
    logic t;
    @(posedge aclk);
    araddr <= a;
    arvalid <= 1;
    rready <= 1;
    do begin
      @(negedge aclk);
      t = arready;
      @(posedge aclk);
    end while (!t);
    arvalid <= 0;
    do @(negedge aclk); while (!rvalid);
    rd = rdata;
    rsp = rresp;
    @(posedge aclk);
    rready <= 0;
  endtask
  task cf();
    @(negedge aclk);
    chk("flags", {16'h0, flags}, {16'h0, ex});
  endtask
  task hold(input logic [2:0] lv, input int n);
    @(posedge aclk);
    ln <= lv;
    repeat (n - 1) @(posedge aclk);
  endtask
  // Flags raised by one stimulus step, given the previous levels
  function automatic logic [15:0] ev(input logic [5:0] o, input logic [5:0] n,
                                     input logic s);
    ev = 16'h0;
    ev[10] = n[0];
    ev[8] = s ? n[1] : n[2];
    ev[5:3] = o[5:3] ^ n[5:3];
  endfunction
  initial begin
    aclk = 0;
    forever #50 aclk = ~aclk;
  end
  initial begin
    #(100 * 20000);
    fails++;
    summarize();
  end
  initial begin
    seed = 32'h71e1f950;
    {aresetn, awvalid, wvalid, bready, arvalid, rready} = 6'h0;
    {awaddr, araddr, wdata} = 40'h0;
    ln = 3'h0;
    st = 6'h0;
    ex = 16'h0;
    repeat (20) @(posedge aclk);
    aresetn <= 1;
    for (int a = 0; a < 16; a += 4) begin
      rdr(a[3:0]);
      chk("reset value", rd, 32'h0);
    end
    rdr(4'h6);
    chk("unmapped resp", {30'h0, rsp}, {30'h0, OEFL_RESP_SLVERR});
    wr(4'h4, 32'hFFFFFFFF);
    chk("write resp", {30'h0, rsp}, {30'h0, OEFL_RESP_OKAY});
    wr(4'h6, 32'h0);
    chk("unmapped write", {30'h0, rsp}, {30'h0, OEFL_RESP_SLVERR});
    rdr(4'h4);
    chk("enables", rd, {16'h0, OEFL_ENABLE_MASK});
    $display("test registers done");
    for (int sel = 0; sel < 2; sel++) begin
      wr(4'h8, {22'h0, sel[0], 9'h0});
      wr(4'h4, {21'h0, sel[0], 10'h0});
      for (int i = 0; i < 40; i++) begin
        v = 6'($random(seed));
        ex = ex | ev(st, v, sel[0]);
        @(posedge aclk);
        st <= v;
        @(posedge aclk);
        st[2:0] <= 3'h0;
        cf();
        chk("irq", {31'h0, irq}, {31'h0, ex[10] & sel[0]});
        if (i % 8 == 7) begin
          m = $random(seed);
          wr(4'h0, m);
          ex = ex & ~m[15:0];
          rdr(4'h0);
          chk("flags read", rd, {16'h0, ex});
        end
      end
    end
    rdr(OEFL_OFS_STATE);
    chk("state levels", rd, 32'(st[5:3]) << OEFL_BIT_ASV);
    fork
      wr(4'h0, 32'h20);
      begin
        // Toggle lands in the cycle of the clearing write
        repeat (2) @(posedge aclk);
        st[5] <= !st[5];
      end
    join
    ex[5] = 1'b1;
    cf();
    wr(4'h0, 32'hFFFF);
    ex = 16'h0;
    $display("test events done");
    for (int k = L; k <= L + 1; k++) begin
      hold(3'b100, k);
      hold(3'b000, 3);
      ex[9] = (k > L);
      cf();
    end
    hold(3'b010, 1);
    hold(3'b001, 1);
    hold(3'b010, S);
    hold(3'b000, 2);
    cf();
    hold(3'b010, S + 2);
    ex[6] = 1'b1;
    cf();
    hold(3'b001, 1);
    hold(3'b000, 2);
    ex[7] = 1'b1;
    cf();
    $display("test line states done");
    summarize();
  end
endmodule
